// ### gcn_pin_model.sv
// Model of the package pins: port drivers, weak pulls and an external source.
// Assumes the bench sets the external source; an undriven pin wanders each cycle.
`timescale 1ns/100ps
module gcn_pin_model (
   input wire logic sys_clk,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] pullup_en,
   input wire logic [15:0] pulldown_en,
   input wire logic ext_en,
   input wire logic [15:0] ext_val,
   output logic [15:0] pin_level
);
   // ----------------------------------------------------------------
   // Pin resolution
   // ----------------------------------------------------------------
   logic wander_r = 1'b0;
   always @(posedge sys_clk) begin
      wander_r <= ~wander_r;
   end
   // A floating pin must not look stable, or a stuck input would go unseen.
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         if (pin_oe[i]) pin_level[i] = pin_out[i];
         else if (ext_en) pin_level[i] = ext_val[i];
         else if (pullup_en[i]) pin_level[i] = 1'b1;
         else if (pulldown_en[i]) pin_level[i] = 1'b0;
         else pin_level[i] = wander_r;
      end
   end
endmodule

// ### gcn_pkg.sv
// Constants shared by the I/O port block with change notification.
// Assumes byte addresses on a 16-bit register port, 32-bit data words.
package gcn_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [15:0] OFS_PIN_LEVEL = 16'h5320;
   localparam logic [15:0] OFS_ANALOG_SELECT = 16'h6300;
   localparam logic [15:0] OFS_PIN_DIRECTION = 16'h6310;
   localparam logic [15:0] OFS_OUTPUT_LATCH = 16'h6330;
   localparam logic [15:0] OFS_OPEN_DRAIN = 16'h6340;
   localparam logic [15:0] OFS_PULLUP = 16'h6350;
   localparam logic [15:0] OFS_PULLDOWN = 16'h6360;
   localparam logic [15:0] OFS_NOTIFY_CONTROL = 16'h6370;
   localparam logic [15:0] OFS_IRQ_ENABLE = 16'h6380;
   localparam logic [15:0] OFS_CHANGE_STATUS = 16'h6390;
   // -----------------------------------------------------------------
   // Alias offsets added to a base address
   // -----------------------------------------------------------------
   localparam logic [15:0] ALIAS_MASK = 16'h000c;
   localparam logic [1:0] ALIAS_BASE = 2'h0;
   localparam logic [1:0] ALIAS_CLR = 2'h1;
   localparam logic [1:0] ALIAS_SET = 2'h2;
   localparam logic [1:0] ALIAS_TOGGLE = 2'h3;
   localparam int ALIAS_LSB = 2;
   // -----------------------------------------------------------------
   // Fields and reset values
   // -----------------------------------------------------------------
   localparam int CTRL_ON_BIT = 15;
   localparam int CTRL_STOP_IN_IDLE_BIT = 13;
   localparam logic [15:0] RST_ANALOG_SELECT = 16'h000e;
   localparam logic [15:0] RST_DIRECTION = 16'hffff;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam int PORT_WIDTH = 16;
   localparam int DATA_WIDTH = 32;
   localparam int ADDR_WIDTH = 16;
endpackage

// ### gcn_port.sv
// Sixteen-pin digital I/O port with change notification and atomic aliases.
// Assumes a single-cycle register port and pins outside the clock domain.
//
// Function
// - Direction bit one means input, zero output.
// - Every pin is an input after reset.
// - Output latch reads back and writes latch.
// - Pin level reads pins; writes go to latch.
// - Open-drain bit drives low only, releases high.
// - Analog select resets to ones where implemented.
// - Analog input pins read zero from pin level.
// - Digital input pins are not routed to converter.
// - Enabled pin change raises interrupt request.
// - Change detection keeps working in sleep; here it needs the clock, and stops in idle when stop-in-idle is set.
// - Status shows change since last pin level read.
// - Weak pull-up and pull-down enabled separately.
// - Aliases set, clear or toggle one bits only.
// - Clear, set, toggle aliases at plus 4, 8, 12.
// - Alias reads return undefined data; here they read zero.
// - Upper half and unimplemented bits read zero.
`timescale 1ns/100ps
module gcn_port #(
   parameter int WIDTH = gcn_pkg::PORT_WIDTH,
   parameter logic [15:0] ANALOG_MASK = gcn_pkg::RST_ANALOG_SELECT,
   parameter logic [15:0] PIN_MASK = 16'hffff
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [gcn_pkg::ADDR_WIDTH-1:0] reg_addr,
   input wire logic [gcn_pkg::DATA_WIDTH-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [gcn_pkg::DATA_WIDTH-1:0] reg_rdata,
   input wire logic idle_mode,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pullup_en,
   output logic [WIDTH-1:0] pulldown_en,
   output logic [WIDTH-1:0] analog_route,
   output logic [WIDTH-1:0] digital_in_en,
   output logic change_irq
);
   // -----------------------------------------------------------------
   // Parameter check
   // -----------------------------------------------------------------
   initial begin
      if (WIDTH < 1 || WIDTH > 16) begin
         $error("gcn_port: WIDTH must lie between 1 and 16");
      end
   end

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   // Applies a base write or one of the three alias operations.
   function automatic logic [WIDTH-1:0] apply_op(
      input logic [WIDTH-1:0] old,
      input logic [WIDTH-1:0] wd,
      input logic [1:0] op
   );
      logic [WIDTH-1:0] res;
      res = old;
      case (op)
         gcn_pkg::ALIAS_BASE: res = wd;
         gcn_pkg::ALIAS_CLR: res = old & ~wd;
         gcn_pkg::ALIAS_SET: res = old | wd;
         gcn_pkg::ALIAS_TOGGLE: res = old ^ wd;
         default: res = old;
      endcase
      return res;
   endfunction

   // True when the address falls in the group of the given base.
   function automatic logic hit(
      input logic [gcn_pkg::ADDR_WIDTH-1:0] a,
      input logic [gcn_pkg::ADDR_WIDTH-1:0] base
   );
      return (a & ~gcn_pkg::ALIAS_MASK) == base;
   endfunction

   // -----------------------------------------------------------------
   // Decode
   // -----------------------------------------------------------------
   logic [1:0] op;
   logic [WIDTH-1:0] wd;
   logic [WIDTH-1:0] pin_mask_w;
   logic [WIDTH-1:0] ana_mask_w;
   logic wr_ansel;
   logic wr_dir;
   logic wr_lat;
   logic wr_odc;
   logic wr_pu;
   logic wr_pd;
   logic wr_ctl;
   logic wr_ien;

   assign op = reg_addr[gcn_pkg::ALIAS_LSB +: 2];
   assign pin_mask_w = PIN_MASK[WIDTH-1:0];
   assign ana_mask_w = ANALOG_MASK[WIDTH-1:0];
   assign wd = reg_wdata[WIDTH-1:0] & pin_mask_w;
   assign wr_ansel = reg_wr && hit(reg_addr, gcn_pkg::OFS_ANALOG_SELECT);
   assign wr_dir = reg_wr && hit(reg_addr, gcn_pkg::OFS_PIN_DIRECTION);
   assign wr_lat = reg_wr && (hit(reg_addr, gcn_pkg::OFS_OUTPUT_LATCH)
                              || hit(reg_addr, gcn_pkg::OFS_PIN_LEVEL));
   assign wr_odc = reg_wr && hit(reg_addr, gcn_pkg::OFS_OPEN_DRAIN);
   assign wr_pu = reg_wr && hit(reg_addr, gcn_pkg::OFS_PULLUP);
   assign wr_pd = reg_wr && hit(reg_addr, gcn_pkg::OFS_PULLDOWN);
   assign wr_ctl = reg_wr && hit(reg_addr, gcn_pkg::OFS_NOTIFY_CONTROL);
   assign wr_ien = reg_wr && hit(reg_addr, gcn_pkg::OFS_IRQ_ENABLE);

   // -----------------------------------------------------------------
   // Configuration registers
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] ansel_r;
   logic [WIDTH-1:0] dir_r;
   logic [WIDTH-1:0] lat_r;
   logic [WIDTH-1:0] odc_r;
   logic [WIDTH-1:0] pu_r;
   logic [WIDTH-1:0] pd_r;
   logic [WIDTH-1:0] ien_r;
   logic on_r;
   logic stop_in_idle_r;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ansel_r <= gcn_pkg::RST_ANALOG_SELECT[WIDTH-1:0] & ana_mask_w;
      end else if (wr_ansel) begin
         ansel_r <= apply_op(ansel_r, wd, op) & ana_mask_w;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dir_r <= gcn_pkg::RST_DIRECTION[WIDTH-1:0];
      end else if (wr_dir) begin
         dir_r <= apply_op(dir_r, wd, op);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         lat_r <= gcn_pkg::RST_ZERO[WIDTH-1:0];
      end else if (wr_lat) begin
         lat_r <= apply_op(lat_r, wd, op);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         odc_r <= gcn_pkg::RST_ZERO[WIDTH-1:0];
      end else if (wr_odc) begin
         odc_r <= apply_op(odc_r, wd, op);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pu_r <= gcn_pkg::RST_ZERO[WIDTH-1:0];
         pd_r <= gcn_pkg::RST_ZERO[WIDTH-1:0];
      end else begin
         if (wr_pu) begin
            pu_r <= apply_op(pu_r, wd, op);
         end
         if (wr_pd) begin
            pd_r <= apply_op(pd_r, wd, op);
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         ien_r <= gcn_pkg::RST_ZERO[WIDTH-1:0];
      end else if (wr_ien) begin
         ien_r <= apply_op(ien_r, wd, op);
      end
   end

   // Only the on and stop-in-idle bits exist; the rest read zero.
   logic [1:0] ctl_old;
   logic [1:0] ctl_wd;
   logic [1:0] ctl_new;
   assign ctl_old = {on_r, stop_in_idle_r};
   assign ctl_wd = {reg_wdata[gcn_pkg::CTRL_ON_BIT], reg_wdata[gcn_pkg::CTRL_STOP_IN_IDLE_BIT]};
   always_comb begin
      ctl_new = ctl_old;
      case (op)
         gcn_pkg::ALIAS_BASE: ctl_new = ctl_wd;
         gcn_pkg::ALIAS_CLR: ctl_new = ctl_old & ~ctl_wd;
         gcn_pkg::ALIAS_SET: ctl_new = ctl_old | ctl_wd;
         gcn_pkg::ALIAS_TOGGLE: ctl_new = ctl_old ^ ctl_wd;
         default: ctl_new = ctl_old;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         on_r <= 1'b0;
         stop_in_idle_r <= 1'b0;
      end else if (wr_ctl) begin
         on_r <= ctl_new[1];
         stop_in_idle_r <= ctl_new[0];
      end
   end

   // -----------------------------------------------------------------
   // Pin input path
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] pin_sync;
   logic [WIDTH-1:0] pin_prev_r;
   logic [WIDTH-1:0] analog_in;
   logic [WIDTH-1:0] level_view;

   gcn_sync #(
      .WIDTH(WIDTH)
   ) u_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .async_in(pin_in),
      .sync_out(pin_sync)
   );

   assign analog_in = ansel_r & dir_r;
   assign level_view = pin_sync & ~analog_in & pin_mask_w;

   // -----------------------------------------------------------------
   // Change notification
   // -----------------------------------------------------------------
   // Detection runs on the synchronised levels, so a change shorter than
   // one clock period may be missed; with the clock stopped the request
   // path needs an asynchronous wake source outside this block.
   logic notify_active;
   logic rd_level;
   logic [WIDTH-1:0] changed;
   logic [WIDTH-1:0] status_r;

   assign notify_active = on_r && !(stop_in_idle_r && idle_mode);
   assign rd_level = reg_rd && reg_addr == gcn_pkg::OFS_PIN_LEVEL;
   assign changed = (pin_sync ^ pin_prev_r) & ien_r & pin_mask_w;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         pin_prev_r <= '0;
      end else begin
         pin_prev_r <= pin_sync;
      end
   end

   // A change in the same cycle as the clearing read stays recorded.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         status_r <= '0;
      end else begin
         status_r <= (rd_level ? '0 : status_r)
                     | (notify_active ? changed : '0);
      end
   end

   assign change_irq = notify_active && |(status_r & ien_r);

   // -----------------------------------------------------------------
   // Pin drive
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] is_out;
   assign is_out = ~dir_r & pin_mask_w;
   // Open-drain pins only sink: the enable is dropped for a high level.
   assign pin_oe = is_out & ~(odc_r & lat_r);
   assign pin_out = lat_r & ~odc_r;
   assign pullup_en = pu_r;
   assign pulldown_en = pd_r;
   assign analog_route = ansel_r;
   assign digital_in_en = ~ansel_r;

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] rd_val;
   logic [gcn_pkg::DATA_WIDTH-1:0] rd_word;

   always_comb begin
      rd_val = '0;
      if (reg_addr[gcn_pkg::ALIAS_LSB +: 2] == gcn_pkg::ALIAS_BASE) begin
         case (reg_addr)
            gcn_pkg::OFS_PIN_LEVEL: rd_val = level_view;
            gcn_pkg::OFS_ANALOG_SELECT: rd_val = ansel_r;
            gcn_pkg::OFS_PIN_DIRECTION: rd_val = dir_r;
            gcn_pkg::OFS_OUTPUT_LATCH: rd_val = lat_r;
            gcn_pkg::OFS_OPEN_DRAIN: rd_val = odc_r;
            gcn_pkg::OFS_PULLUP: rd_val = pu_r;
            gcn_pkg::OFS_PULLDOWN: rd_val = pd_r;
            gcn_pkg::OFS_IRQ_ENABLE: rd_val = ien_r;
            gcn_pkg::OFS_CHANGE_STATUS: rd_val = status_r;
            default: rd_val = '0;
         endcase
      end
   end

   // Alias reads and unmapped reads both return zero.
   always_comb begin
      rd_word = '0;
      rd_word[WIDTH-1:0] = rd_val & pin_mask_w;
      if (reg_addr == gcn_pkg::OFS_NOTIFY_CONTROL) begin
         rd_word[gcn_pkg::CTRL_ON_BIT] = on_r;
         rd_word[gcn_pkg::CTRL_STOP_IN_IDLE_BIT] = stop_in_idle_r;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= rd_word;
      end else begin
         reg_rdata <= '0;
      end
   end
endmodule

// ### gcn_port_checker.sv
// Concurrent checks on the ports of the I/O port block.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/100ps
module gcn_port_checker #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic idle_mode,
   input wire logic [WIDTH-1:0] pin_in,
   input wire logic [WIDTH-1:0] pin_out,
   input wire logic [WIDTH-1:0] pin_oe,
   input wire logic [WIDTH-1:0] pullup_en,
   input wire logic [WIDTH-1:0] pulldown_en,
   input wire logic [WIDTH-1:0] analog_route,
   input wire logic [WIDTH-1:0] digital_in_en,
   input wire logic change_irq
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   a_reset_inputs: assert property (!rstn |=> ~|pin_oe)
      else $error("pin driven after reset");
   a_rdata_quiet: assert property (disable iff (!rstn) !reg_rd |=> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_upper_zero: assert property (disable iff (!rstn) reg_rd |=> reg_rdata[31:16] == 16'h0)
      else $error("upper read half not zero");
   a_analog_split: assert property (disable iff (!rstn) analog_route == ~digital_in_en)
      else $error("pin both analog and digital");
   a_pins_hold: assert property (disable iff (!rstn) !reg_wr |=> $stable(pin_oe) && $stable(pin_out))
      else $error("pin drive changed without a write");
   a_pulls_hold: assert property (disable iff (!rstn) !reg_wr |=> $stable(pullup_en) && $stable(pulldown_en))
      else $error("pull changed without a write");
   // A request may also rise from an enable write or the end of idle, so those cycles are left out.
   a_irq_cause: assert property (disable iff (!rstn) $rose(change_irq) && !$past(reg_wr) && !$past(idle_mode)
      |-> $past(pin_in, 2) != $past(pin_in, 5))
      else $error("request without a pin change");
   a_irq_release: assert property (disable iff (!rstn) $fell(change_irq)
      |-> $past(reg_wr) || $past(reg_rd) || $past(reg_rd, 2) || idle_mode)
      else $error("request dropped without a read or write");
endmodule

bind gcn_port gcn_port_checker #(.WIDTH(WIDTH)) u_chk (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode),
   .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .pulldown_en(pulldown_en),
   .analog_route(analog_route), .digital_in_en(digital_in_en), .change_irq(change_irq));

// ### gcn_sync.sv
// Two-stage synchroniser for a bus of independent pin levels.
// Assumes each bit is asynchronous to clk and is sampled on its own.
`timescale 1ns/100ps
module gcn_sync #(
   parameter int WIDTH = 16
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   initial begin
      if (WIDTH < 1) begin
         $error("gcn_sync: WIDTH must be at least one");
      end
   end

   // Only the second stage reads the first one.
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         meta_r <= '0;
         sync_out <= '0;
      end else begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ### tb_top.sv
// Self-checking bench for the I/O port block with change notification.
// Assumes the pin model and the bound checker beside the design.
`timescale 1ns/100ps
module tb_top;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] reg_addr = 16'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic idle_mode = 1'b0;
   logic ext_en = 1'b1;
   logic [15:0] ext_val = 16'h0;
   logic [31:0] reg_rdata;
   logic [15:0] pin_in, pin_out, pin_oe, pullup_en, pulldown_en, analog_route, digital_in_en;
   logic change_irq;
   logic [31:0] alias_wd [1:3] = '{32'h30, 32'h8001, 32'hff};
   logic [31:0] alias_exp [1:3] = '{32'h1204, 32'h9205, 32'h92fa};
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   always #50 sys_clk = ~sys_clk;
   gcn_port uut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .idle_mode(idle_mode), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pullup_en(pullup_en), .pulldown_en(pulldown_en), .analog_route(analog_route),
      .digital_in_en(digital_in_en), .change_irq(change_irq));
   gcn_pin_model pins (.sys_clk(sys_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .pulldown_en(pulldown_en), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
   // ----------------------------------------------------------------
   // Access tasks
   // ----------------------------------------------------------------
   task automatic end_of_test();
      $display("Counts: errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      // Returning off the edge keeps a following write from driving the strobe twice in one step.
      #1;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken just past that edge.
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask
   task automatic toggle_wait(input logic [15:0] v);
      ext_val <= v;
      repeat (5) @(posedge sys_clk);
      #1;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 1000) begin
         n_errors++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      #1;
      chk({16'h0, pin_oe}, 32'h0);
      rd(gcn_pkg::OFS_PIN_DIRECTION, 32'hffff);
      rd(gcn_pkg::OFS_ANALOG_SELECT, 32'he);
      rd(gcn_pkg::OFS_NOTIFY_CONTROL, 32'h0);
      rd(16'h6400, 32'h0);
      wr(gcn_pkg::OFS_OUTPUT_LATCH, 32'hffffa5c3);
      rd(gcn_pkg::OFS_OUTPUT_LATCH, 32'ha5c3);
      wr(gcn_pkg::OFS_PIN_LEVEL, 32'h1234);
      rd(gcn_pkg::OFS_OUTPUT_LATCH, 32'h1234);
      for (int i = 1; i < 4; i++) begin
         wr(gcn_pkg::OFS_OUTPUT_LATCH + 16'(4 * i), alias_wd[i]);
         rd(gcn_pkg::OFS_OUTPUT_LATCH, alias_exp[i]);
         rd(gcn_pkg::OFS_OUTPUT_LATCH + 16'(4 * i), 32'h0);
      end
      ext_val <= 16'h5a00;
      wr(gcn_pkg::OFS_PIN_DIRECTION, 32'hff00);
      #1;
      chk({pin_oe, pin_out & pin_oe}, 32'h00ff00fa);
      repeat (3) @(posedge sys_clk);
      rd(gcn_pkg::OFS_PIN_LEVEL, 32'h5afa);
      wr(gcn_pkg::OFS_OPEN_DRAIN, 32'hf);
      #1;
      // The output value is the latch with open-drain bits forced low, whatever the enable.
      chk({pin_oe, pin_out}, 32'h00f592f0);
      wr(gcn_pkg::OFS_PIN_DIRECTION, 32'hffff);
      wr(gcn_pkg::OFS_OPEN_DRAIN, 32'h0);
      wr(gcn_pkg::OFS_PULLUP, 32'hf0);
      wr(gcn_pkg::OFS_PULLDOWN, 32'hf00);
      #1;
      chk({pullup_en, pulldown_en}, 32'h00f00f00);
      toggle_wait(16'hffff);
      rd(gcn_pkg::OFS_PIN_LEVEL, 32'hfff1);
      chk({analog_route, digital_in_en}, 32'h000efff1);
      wr(gcn_pkg::OFS_PULLUP, 32'h0);
      wr(gcn_pkg::OFS_PULLDOWN, 32'h0);
      wr(gcn_pkg::OFS_IRQ_ENABLE, 32'h10);
      wr(gcn_pkg::OFS_NOTIFY_CONTROL, 32'h8000);
      rd(gcn_pkg::OFS_PIN_LEVEL, 32'hfff1);
      toggle_wait(16'hffef);
      chk({31'h0, change_irq}, 32'h1);
      rd(gcn_pkg::OFS_CHANGE_STATUS, 32'h10);
      rd(gcn_pkg::OFS_PIN_LEVEL, 32'hffe1);
      @(posedge sys_clk);
      rd(gcn_pkg::OFS_CHANGE_STATUS, 32'h0);
      chk({31'h0, change_irq}, 32'h0);
      wr(gcn_pkg::OFS_NOTIFY_CONTROL, 32'h0);
      toggle_wait(16'hffff);
      rd(gcn_pkg::OFS_CHANGE_STATUS, 32'h0);
      wr(gcn_pkg::OFS_NOTIFY_CONTROL, 32'ha000);
      idle_mode <= 1'b1;
      toggle_wait(16'hffef);
      chk({31'h0, change_irq}, 32'h0);
      rd(gcn_pkg::OFS_CHANGE_STATUS, 32'h0);
      idle_mode <= 1'b0;
      repeat (2) @(posedge sys_clk);
      // Clearing one analog select bit through its alias hands that pin back to digital reads.
      wr(gcn_pkg::OFS_ANALOG_SELECT + 16'h4, 32'h2);
      rd(gcn_pkg::OFS_ANALOG_SELECT, 32'hc);
      rd(gcn_pkg::OFS_PIN_LEVEL, 32'hffe3);
      end_of_test();
   end
endmodule
